// ==== sdie_encoder.sv ====
// sdi video encoder: clipper, word fifo, word/half/bit rate scrambler and nrzi
`timescale 1ns/1ps
// What this block does
// [R1] clip enabled, upper eight bits all zero: force two low bits to zero
// [R2] clip enabled, upper eight bits all one: force two low bits to one
// [R3] other words pass unaltered; upper eight bits always pass
// [R4] clip enable input; when low every word passes untouched
// [R5] clipper is purely combinational, same cycle as its input
// [R6] bit-rate mode scrambles one serial bit per clock
// [R7] separate enables bypass the scrambling stage and the nrzi stage
// [R8] controlling logic holds both enables high for compliant streams
// [R9] half-rate mode encodes two consecutive bits per clock for a ddr stage
// [R10] word-rate mode: ten-bit word in and out each clock, three cycles latency from input through fifo
// [R11] each scrambled bit is three-input xor of data and the fourth and ninth held bits
// [R12] scrambled six low bits feed back to make the six high bits
// [R13] word nrzi xors each bit with its predecessor, eleventh is last msb
// [R14] half-rate clock is five times word clock; ddr phases 180 apart
// [R15] half-rate serializer shifts two bits per cycle, one word per five
// [R16] clipper output feeds the word fifo, then the scrambler, which serializes in half and bit rate
// [R17] optional reference clock driven as ddr phase pair for even duty
// [R18] word-rate path uses the word scrambler; pass-through mode omitted
// [R19] scrambling divides by x^9 + x^4 + 1
// [R20] nrzi conversion uses x + 1
// [R21] least significant bit of each word goes first
// [R22] synchronous clear zeroes scrambler state and nrzi history
// [R23] all modes give bit-identical serial streams from the same state

module sdie_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // fill side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // drain side
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_q, wp_d;
   logic [AW-1:0] rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          rdy_q, rdy_d;
   logic          push;
   logic          pop;

   always_comb begin
      push  = in_valid_i & rdy_q;
      pop   = out_ready_i & (cnt_q != '0);
      wp_d  = wp_q;
      rp_d  = rp_q;
      if (push) begin
         wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      rdy_d = (cnt_d != (AW + 1)'(D));
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b1;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_q] <= in_data_i;
      end
   end

   assign in_ready_o  = rdy_q;
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem[rp_q];
endmodule

module sdie_encoder #(
   parameter int DEPTH = sdie_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       sync_clr_i,
   // control pins
   input  wire logic       clip_en_i,
   input  wire logic       scram_en_i,
   input  wire logic       nrzi_en_i,
   input  wire logic [1:0] mode_i,
   // parallel video in
   input  wire logic       vid_valid_i,
   input  wire logic [9:0] vid_word_i,
   output logic            vid_ready_o,
   // downstream
   input  wire logic       out_ready_i,
   output logic            enc_valid_o,
   output logic [9:0]      enc_word_o,
   output logic            ser_valid_o,
   output logic [1:0]      ser_bits_o,
   output logic [1:0]      ref_clk_o
);
   sdie_pkg::sdie_ctl_t ctl_raw, ctl_m_q, ctl_q;
   logic [9:0]          clip_word;
   logic                f_valid;
   logic [9:0]          f_data;
   logic                f_pop;
   logic [8:0]          scr_q, scr_d;
   logic                nz_q, nz_d;
   logic [9:0]          s1_q, s1_d;
   logic                s1v_q, s1v_d;
   logic [9:0]          enc_q, enc_d;
   logic                encv_q, encv_d;
   logic [9:0]          sh_q, sh_d;
   logic [3:0]          cnt_q, cnt_d;
   logic [1:0]          ser_q, ser_d;
   logic                serv_q, serv_d;
   logic [1:0]          ref_q, ref_d;
   sdie_pkg::sdie_scr_t  sc;
   sdie_pkg::sdie_nrzi_t nr;
   logic [3:0]          k;
   logic [3:0]          left;
   logic [9:0]          src;
   logic                have;

   // control pins through two flops
   assign ctl_raw = '{mode: mode_i, nrzi_en: nrzi_en_i, scram_en: scram_en_i, clip_en: clip_en_i};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_m_q <= '0;
         ctl_q   <= '0;
      end else begin
         ctl_m_q <= ctl_raw;
         ctl_q   <= ctl_m_q;
      end
   end

   // [R5] combinational clipper
   always_comb begin
      clip_word = vid_word_i;
      // [R1] [R4] all-zero clip
      if (ctl_q.clip_en && (vid_word_i[9:2] == 8'h00)) begin
         clip_word[1:0] = 2'h0;
      // [R2] all-one clip
      end else if (ctl_q.clip_en && (vid_word_i[9:2] == 8'hff)) begin
         clip_word[1:0] = 2'h3;
      end
      // [R3] otherwise unchanged
   end

   // [R16] clipped words buffered ahead of the scrambler
   sdie_fifo #(
      .W (sdie_pkg::WORD_W),
      .D (DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (vid_valid_i),
      .in_data_i   (clip_word),
      .in_ready_o  (vid_ready_o),
      .out_valid_o (f_valid),
      .out_data_o  (f_data),
      .out_ready_i (f_pop)
   );

   always_comb begin
      f_pop  = 1'b0;
      scr_d  = scr_q;
      nz_d   = nz_q;
      s1_d   = s1_q;
      s1v_d  = s1v_q;
      enc_d  = enc_q;
      encv_d = encv_q;
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      ser_d  = ser_q;
      serv_d = serv_q;
      ref_d  = sdie_pkg::REF_PHASES;
      sc     = '0;
      nr     = '0;
      k      = sdie_pkg::BITS_HALF;
      left   = cnt_q;
      src    = sh_q;
      have   = 1'b1;
      // [R22] synchronous clear of coder state
      if (sync_clr_i) begin
         scr_d  = sdie_pkg::SCR_RST;
         nz_d   = sdie_pkg::NRZI_RST;
         s1v_d  = 1'b0;
         encv_d = 1'b0;
         cnt_d  = sdie_pkg::CNT_RST;
         serv_d = 1'b0;
      end else if (out_ready_i) begin
         if (ctl_q.mode == sdie_pkg::SDIE_MODE_WORD) begin
            // [R10] [R18] stage one: word scrambler
            f_pop  = f_valid;
            // [R11] [R12] [R19] ten three-input xors with in-word feedback
            sc     = sdie_pkg::scramble(scr_q, f_data, sdie_pkg::BITS_WORD, ctl_q.scram_en);
            s1_d   = sc.bits;
            s1v_d  = f_valid;
            if (f_valid) begin
               scr_d = sc.st;
            end
            // [R13] [R20] stage two: nrzi using last output msb
            nr     = sdie_pkg::nrzi(nz_q, s1_q, sdie_pkg::BITS_WORD, ctl_q.nrzi_en);
            encv_d = s1v_q;
            if (s1v_q) begin
               enc_d = nr.bits;
               nz_d  = nr.last;
            end
            serv_d = 1'b0;
         end else begin
            // [R6] [R9] [R15] one or two bits per clock
            k = (ctl_q.mode == sdie_pkg::SDIE_MODE_BIT) ? sdie_pkg::BITS_BIT : sdie_pkg::BITS_HALF;
            if (cnt_q == sdie_pkg::CNT_RST) begin
               src  = f_data;
               have = f_valid;
               left = sdie_pkg::BITS_WORD;
            end
            encv_d = 1'b0;
            s1v_d  = 1'b0;
            serv_d = have;
            if (have) begin
               f_pop  = (cnt_q == sdie_pkg::CNT_RST);
               // [R7] [R23] same coder state as word mode, stages bypassable
               sc     = sdie_pkg::scramble(scr_q, src, k, ctl_q.scram_en);
               nr     = sdie_pkg::nrzi(nz_q, sc.bits, k, ctl_q.nrzi_en);
               scr_d  = sc.st;
               nz_d   = nr.last;
               // [R21] [R14] bit 0 leaves first, on the rising phase
               ser_d  = nr.bits[1:0];
               sh_d   = src >> k;
               cnt_d  = left - k;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scr_q  <= sdie_pkg::SCR_RST;
         nz_q   <= sdie_pkg::NRZI_RST;
         s1_q   <= '0;
         s1v_q  <= 1'b0;
         enc_q  <= '0;
         encv_q <= 1'b0;
         sh_q   <= '0;
         cnt_q  <= sdie_pkg::CNT_RST;
         ser_q  <= '0;
         serv_q <= 1'b0;
         ref_q  <= sdie_pkg::REF_IDLE;
      end else begin
         scr_q  <= scr_d;
         nz_q   <= nz_d;
         s1_q   <= s1_d;
         s1v_q  <= s1v_d;
         enc_q  <= enc_d;
         encv_q <= encv_d;
         sh_q   <= sh_d;
         cnt_q  <= cnt_d;
         ser_q  <= ser_d;
         serv_q <= serv_d;
         // [R17] reference clock phase pair
         ref_q  <= ref_d;
      end
   end

   assign enc_valid_o = encv_q;
   assign enc_word_o  = enc_q;
   assign ser_valid_o = serv_q;
   assign ser_bits_o  = ser_q;
   assign ref_clk_o   = ref_q;
endmodule

// ==== sdie_pkg.sv ====
// package: constants, types and coding functions for the sdi video encoder
package sdie_pkg;

   // word and scrambler geometry
   localparam int          WORD_W     = 10;
   localparam int          STATE_W    = 9;
   localparam int          CLIP_LO_W  = 2;
   localparam int          TAP_X4     = 3;
   localparam int          TAP_X9     = 8;
   localparam int          FIFO_DEPTH = 16;

   // bits emitted per clock in each mode
   localparam logic [3:0]  BITS_WORD  = 4'ha;
   localparam logic [3:0]  BITS_HALF  = 4'h2;
   localparam logic [3:0]  BITS_BIT   = 4'h1;

   // reset values and the driven reference phase pair
   localparam logic [8:0]  SCR_RST    = 9'h000;
   localparam logic        NRZI_RST   = 1'b0;
   localparam logic [3:0]  CNT_RST    = 4'h0;
   localparam logic [1:0]  REF_IDLE   = 2'h0;
   localparam logic [1:0]  REF_PHASES = 2'h1;

   typedef enum logic [1:0] {
      SDIE_MODE_WORD = 2'h0,
      SDIE_MODE_HALF = 2'h1,
      SDIE_MODE_BIT  = 2'h2
   } sdie_mode_t;

   typedef struct packed {
      logic [1:0] mode;
      logic       nrzi_en;
      logic       scram_en;
      logic       clip_en;
   } sdie_ctl_t;

   typedef struct packed {
      logic [STATE_W-1:0] st;
      logic [WORD_W-1:0]  bits;
   } sdie_scr_t;

   typedef struct packed {
      logic               last;
      logic [WORD_W-1:0]  bits;
   } sdie_nrzi_t;

   // divide by x^9 + x^4 + 1, lsb first; st[0] is the newest scrambled bit
   function automatic sdie_scr_t scramble(input logic [STATE_W-1:0] st, input logic [WORD_W-1:0] d,
                                         input logic [3:0] n, input logic en);
      sdie_scr_t r;
      logic      y;
      r.st   = st;
      r.bits = '0;
      y      = 1'b0;
      for (int i = 0; i < WORD_W; i++) begin
         if (4'(i) < n) begin
            y         = d[i] ^ (en & (r.st[TAP_X4] ^ r.st[TAP_X9]));
            r.bits[i] = y;
            r.st      = {r.st[STATE_W-2:0], y};
         end
      end
      return r;
   endfunction

   // x + 1 conversion to nrzi; bypass passes bits and loads the history with the last passed bit
   function automatic sdie_nrzi_t nrzi(input logic prev, input logic [WORD_W-1:0] d,
                                      input logic [3:0] n, input logic en);
      sdie_nrzi_t r;
      r.last = prev;
      r.bits = '0;
      for (int i = 0; i < WORD_W; i++) begin
         if (4'(i) < n) begin
            r.bits[i] = en ? (d[i] ^ r.last) : d[i];
            r.last    = r.bits[i];
         end
      end
      return r;
   endfunction

endpackage

// ==== sdie_encoder_checker.sv ====
// checker: port timing of the sdi video encoder
`timescale 1ns/1ps
module sdie_encoder_checker (
   // watched encoder ports
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       sync_clr_i,
   input wire logic [1:0] mode_i,
   input wire logic       vid_valid_i,
   input wire logic       vid_ready_o,
   input wire logic       out_ready_i,
   input wire logic       enc_valid_o,
   input wire logic [9:0] enc_word_o,
   input wire logic       ser_valid_o,
   input wire logic [1:0] ser_bits_o,
   input wire logic [1:0] ref_clk_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_take_word;
      vid_valid_i && vid_ready_o && out_ready_i && !sync_clr_i && mode_i == 2'h0 && $past(mode_i, 4) == 2'h0;
   endsequence
   sequence s_flow2;
      (out_ready_i && !sync_clr_i) [*2];
   endsequence
   sequence s_rise(m);
      mode_i == m && $past(mode_i, 4) == m && !sync_clr_i && $rose(ser_valid_o);
   endsequence
   a_ref_pair: assert property (rst_n_i [*2] |-> ref_clk_o == 2'h1)
      else $error("ref pair wrong");
   a_stall_hold: assert property (!out_ready_i && !sync_clr_i |=> $stable(enc_word_o) && $stable(ser_bits_o)
      && $stable(enc_valid_o) && $stable(ser_valid_o)) else $error("output moved in stall");
   a_full_refuse: assert property (!out_ready_i && !$past(out_ready_i) && !vid_ready_o |=> !vid_ready_o)
      else $error("space without pop");
   a_word_latency: assert property (s_take_word ##1 s_flow2 |=> enc_valid_o)
      else $error("word latency wrong");
   a_bit_lsb: assert property (mode_i == 2'h2 && $past(mode_i, 4) == 2'h2 && ser_valid_o |-> !ser_bits_o[1])
      else $error("bit mode uses two bits");
   a_half_run: assert property (s_rise(2'h1) |-> ser_valid_o [*5])
      else $error("half word too short");
   a_bit_run: assert property (s_rise(2'h2) |-> ser_valid_o [*8])
      else $error("bit word too short");
   a_word_no_ser: assert property (mode_i == 2'h0 && $past(mode_i, 4) == 2'h0 |-> !ser_valid_o)
      else $error("serial out in word mode");
endmodule

bind sdie_encoder sdie_encoder_checker sdie_encoder_checker_i (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .sync_clr_i(sync_clr_i), .mode_i(mode_i), .vid_valid_i(vid_valid_i),
   .vid_ready_o(vid_ready_o), .out_ready_i(out_ready_i), .enc_valid_o(enc_valid_o), .enc_word_o(enc_word_o),
   .ser_valid_o(ser_valid_o), .ser_bits_o(ser_bits_o), .ref_clk_o(ref_clk_o));

// ==== sdie_sink.sv ====
// partner model: downstream serializer gathering the line stream
`timescale 1ns/1ps
module sdie_sink (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // pacing and mode
   input  wire logic       stall_i,
   input  wire logic       slow_i,
   input  wire logic [1:0] mode_i,
   // encoder outputs
   input  wire logic       enc_valid_i,
   input  wire logic [9:0] enc_word_i,
   input  wire logic       ser_valid_i,
   input  wire logic [1:0] ser_bits_i,
   output logic            out_ready_o
);
   logic got[$];
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_ready_o <= 1'b0;
      end else begin
         out_ready_o <= !stall_i && !(slow_i && out_ready_o);
         if (out_ready_o && enc_valid_i) begin
            for (int i = 0; i < 10; i++) begin
               got.push_back(enc_word_i[i]);
            end
         end
         if (out_ready_o && ser_valid_i) begin
            got.push_back(ser_bits_i[0]);
            if (mode_i != 2'h2) begin
               got.push_back(ser_bits_i[1]);
            end
         end
      end
   end
endmodule

// ==== tb_top.sv ====
// testbench: sdi video encoder against a bit-serial model
`timescale 1ns/1ps
module tb_top;
   logic       clk_i = 1'b0, rst_n_i = 1'b0, sync_clr_i = 1'b0, clip_en_i = 1'b0, scram_en_i = 1'b0;
   logic       nrzi_en_i = 1'b0, vid_valid_i = 1'b0, stall = 1'b0, slow = 1'b0, last;
   logic       vid_ready_o, out_ready_i, enc_valid_o, ser_valid_o;
   logic [1:0] mode_i = 2'h0, ser_bits_o, ref_clk_o;
   logic [8:0] st;
   logic [9:0] vid_word_i = 10'h000, enc_word_o;
   logic       exp_q[$];
   logic [9:0] pat[$] = '{10'h001, 10'h3fe, 10'h003, 10'h3fc, 10'h155, 10'h004, 10'h3fb, 10'h2aa};
   int         failures = 0, n_compared = 0, cyc = 0;

   sdie_encoder sdie_encoder_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sync_clr_i(sync_clr_i), .clip_en_i(clip_en_i),
      .scram_en_i(scram_en_i), .nrzi_en_i(nrzi_en_i), .mode_i(mode_i), .vid_valid_i(vid_valid_i),
      .vid_word_i(vid_word_i), .vid_ready_o(vid_ready_o), .out_ready_i(out_ready_i),
      .enc_valid_o(enc_valid_o), .enc_word_o(enc_word_o), .ser_valid_o(ser_valid_o),
      .ser_bits_o(ser_bits_o), .ref_clk_o(ref_clk_o));
   sdie_sink sdie_sink_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .slow_i(slow), .mode_i(mode_i),
      .enc_valid_i(enc_valid_o), .enc_word_i(enc_word_o), .ser_valid_i(ser_valid_o),
      .ser_bits_i(ser_bits_o), .out_ready_o(out_ready_i));

   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic cmp(input logic [9:0] g, input logic [9:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic model_word(input logic [9:0] w);
      logic [9:0] c;
      logic       y;
      c = (clip_en_i && w[9:2] == 8'h00) ? {w[9:2], 2'h0} : (clip_en_i && w[9:2] == 8'hff) ? {w[9:2], 2'h3} : w;
      for (int i = 0; i < 10; i++) begin
         y = c[i] ^ (scram_en_i & (st[3] ^ st[8]));
         st = {st[7:0], y};
         last = nrzi_en_i ? (y ^ last) : y;
         exp_q.push_back(last);
      end
   endtask
   task automatic setup(input logic [1:0] m, input logic c, input logic s, input logic n);
      mode_i <= m;
      clip_en_i <= c;
      scram_en_i <= s;
      nrzi_en_i <= n;
      repeat (4) @(posedge clk_i);
      sync_clr_i <= 1'b1;
      @(posedge clk_i);
      sync_clr_i <= 1'b0;
      st = 9'h000;
      last = 1'b0;
      exp_q.delete();
      sdie_sink_i.got.delete();
   endtask
   task automatic send_all(input logic [9:0] ws[$]);
      foreach (ws[k]) begin
         vid_valid_i <= 1'b1;
         vid_word_i <= ws[k];
         // ready read settled, word taken at next rising edge
         @(negedge clk_i);
         while (vid_ready_o !== 1'b1) @(negedge clk_i);
         @(posedge clk_i);
         model_word(ws[k]);
      end
      vid_valid_i <= 1'b0;
   endtask
   task automatic check_stream();
      for (int k = 0; k < 500 && sdie_sink_i.got.size() < exp_q.size(); k++) @(posedge clk_i);
      repeat (12) @(posedge clk_i);
      cmp(10'(sdie_sink_i.got.size()), 10'(exp_q.size()));
      foreach (exp_q[i]) cmp({9'h000, sdie_sink_i.got[i]}, {9'h000, exp_q[i]});
   endtask

   task automatic t_reset();
      cmp({9'h000, enc_valid_o}, 10'h000);
      cmp({8'h00, ref_clk_o}, 10'h001);
   endtask
   task automatic t_word();
      setup(2'h0, 1'b1, 1'b1, 1'b1); // both stages on for compliant data
      send_all(pat);
      check_stream();
   endtask
   task automatic t_bypass();
      for (int k = 0; k < 4; k++) begin
         setup(2'h0, 1'b0, k[1], k[0]);
         send_all(pat);
         check_stream();
      end
   endtask
   task automatic t_half();
      for (int m = 1; m < 4; m += 2) begin
         setup(2'(m), 1'b1, 1'b1, 1'b1);
         slow <= 1'b1;
         send_all(pat);
         check_stream();
         slow <= 1'b0;
      end
   endtask
   task automatic t_bit();
      setup(2'h2, 1'b1, 1'b1, 1'b1);
      send_all(pat);
      check_stream();
   endtask
   task automatic t_fifo_full();
      logic [9:0] ws[$];
      setup(2'h0, 1'b1, 1'b1, 1'b1);
      stall <= 1'b1;
      repeat (2) @(posedge clk_i);
      for (int i = 0; i < 16; i++) ws.push_back(10'(i * 37));
      send_all(ws);
      @(posedge clk_i);
      #1 cmp({9'h000, vid_ready_o}, 10'h000);
      @(posedge clk_i);
      stall <= 1'b0;
      check_stream();
   endtask
   task automatic report_and_stop();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_reset();
      t_word();
      t_bypass();
      t_half();
      t_bit();
      t_fifo_full();
      report_and_stop();
   end
endmodule
